// *** bench/mivc_chk_sva.sv ***
/* assertions on the ports of mivc_top.
   assumes one clock and a synchronous active high reset. */
`timescale 1ns/10ps
module mivc_chk #(
  parameter int NSRC = 23
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [NSRC-1:0] src_req,
  input wire logic trap_req,
  input wire logic [5:0] trap_num,
  input wire logic cpu_ack,
  input wire mivc_pkg::mivc_offer_t irq_offer,
  input wire mivc_pkg::mivc_offer_t trap_offer
);
  // ==========
  // shadow of base, enable and level; accept wins over a flag write
  logic en_q;
  logic [2:0] ppl_q;
  logic [19:0] base_q;
  wire acc = cpu_ack && irq_offer.valid;
  wire flag_wr = reg_wr && reg_addr == 8'h04;
  always_ff @(posedge clk) begin
    if (reset) begin
      en_q <= 1'b0;
      ppl_q <= 3'h0;
      base_q <= 20'h00000;
    end else begin
      if (reg_wr && reg_addr == 8'h00) base_q <= reg_wdata[19:0];
      if (acc) begin
        en_q <= 1'b0;
        ppl_q <= irq_offer.level;
      end else if (flag_wr) begin
        en_q <= reg_wdata[0];
        ppl_q <= reg_wdata[6:4];
      end
    end
  end
  // ==========
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  trap_vec_a: assert property (
    trap_req |=> trap_offer.valid && trap_offer.number == $past(trap_num)
      && trap_offer.vector_addr == $past(base_q) + {$past(trap_num), 2'b00})
    else $error("trap offer wrong");
  trap_once_a: assert property (
    trap_offer.valid |-> $past(trap_req)) else $error("stray trap offer");
  irq_vec_a: assert property (
    irq_offer.valid && $stable(base_q) |->
      irq_offer.vector_addr == base_q + {irq_offer.number, 2'b00})
    else $error("irq vector wrong");
  irq_enable_a: assert property (
    irq_offer.valid |-> $past(en_q)) else $error("offer while disabled");
  irq_level_a: assert property (
    irq_offer.valid |-> irq_offer.level > $past(ppl_q))
    else $error("offer not above level");
  irq_map_a: assert property (
    irq_offer.valid |-> irq_offer.level != 3'h0 &&
      irq_offer.number inside {[7:9], 11, 12, [14:31]})
    else $error("offer outside maskable set");
  accept_drop_a: assert property (
    cpu_ack && irq_offer.valid |=> !irq_offer.valid)
    else $error("offer kept after accept");
  reset_out_a: assert property (
    $fell(reset) |-> !irq_offer.valid && reg_rdata == 32'h0)
    else $error("outputs not clear after reset");
  flag_read_a: assert property (
    reg_rd && reg_addr == 8'h04 |=> reg_rdata[0] == $past(en_q)
      && reg_rdata[6:4] == $past(ppl_q)) else $error("flag word wrong");
  cover property (cpu_ack && irq_offer.valid);
  cover property (trap_offer.valid && trap_offer.number == 6'h00);
  cover property (irq_offer.valid && irq_offer.level == 3'h7);
endmodule // mivc_chk

// *** bench/mivc_core_model.sv ***
/* core model: accepts the offered interrupt after a chosen delay.
   assumes go and delay come from the bench on clk. */
`timescale 1ns/10ps
module mivc_core_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [1:0] delay,
  input wire mivc_pkg::mivc_offer_t irq_offer,
  output logic cpu_ack,
  output mivc_pkg::mivc_offer_t taken_q
);
  logic [1:0] wait_q;
  // ==========
  // one pulse per offer; drops while go is low to let offers stand
  always_ff @(posedge clk) begin
    if (reset || !go || !irq_offer.valid || cpu_ack) begin
      cpu_ack <= 1'b0;
      wait_q <= 2'h0;
    end else if (wait_q == delay) begin
      cpu_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) taken_q <= '0;
    else if (cpu_ack && irq_offer.valid) taken_q <= irq_offer;
  end
endmodule // mivc_core_model

// *** bench/mivc_top_test.sv ***
/* self-checking bench for mivc_top with a core model.
   assumes the checker in mivc_chk_sva.sv is compiled first. */
`timescale 1ns/10ps
module mivc_top_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, trap_req = 1'b0, go = 1'b0;
  logic [22:0] src_req = 23'h0;
  logic [5:0] trap_num = 6'h00;
  logic [1:0] delay = 2'h0;
  logic cpu_ack;
  logic [19:0] base;
  logic [2:0] pr;
  mivc_pkg::mivc_offer_t irq_offer, trap_offer, taken;
  int err_total = 0, n_compared = 0;
  byte nums[23] = '{29, 30, 31, 7, 8, 9, 11, 12, 14, 15, 16, 17, 18, 19,
    20, 21, 22, 23, 24, 25, 26, 27, 28};
  always #50 clk = ~clk;
  mivc_top #(.NSRC(23)) dut_u (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req),
    .trap_req(trap_req), .trap_num(trap_num), .cpu_ack(cpu_ack),
    .irq_offer(irq_offer), .trap_offer(trap_offer));
  mivc_core_model core_u (.clk(clk), .reset(reset), .go(go),
    .delay(delay), .irq_offer(irq_offer), .cpu_ack(cpu_ack),
    .taken_q(taken));
  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic pulse(input logic [22:0] s, input logic t,
    input logic [5:0] n);
    @(posedge clk);
    src_req <= s;
    trap_req <= t;
    trap_num <= n;
    @(posedge clk);
    src_req <= 23'h0;
    trap_req <= 1'b0;
  endtask
  // offer number only matters while it is valid
  task automatic see(input logic v, input logic [5:0] n);
    @(posedge clk);
    #1 chk({25'h0, irq_offer.valid, v ? irq_offer.number : 6'h00},
      {25'h0, v, n});
  endtask
  task automatic wait_ack(input logic [5:0] n);
    int i;
    i = 0;
    while (cpu_ack !== 1'b1 && i < 20) begin
      @(posedge clk);
      #1 i++;
    end
    @(posedge clk);
    #1 chk({26'h0, taken.number}, {26'h0, n});
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========
  // watchdog, far beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end
  // ==========
  // tests
  initial begin
    void'($urandom(32'h7c1d));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h40, 32'h0);
    rd(8'hFC, 32'h0);
    $display("reset test done");
    base = 20'($urandom());
    wr(8'h00, {12'h0, base});
    for (int n = 0; n < 64; n++) begin
      pulse(23'h0, 1'b1, 6'(n));
      #1 chk({5'h0, trap_offer.valid, trap_offer.number,
        trap_offer.vector_addr},
        {5'h0, 1'b1, 6'(n), base + 20'(4 * n)});
      chk({29'h0, trap_offer.level}, 32'h0);
    end
    $display("trap test done");
    go <= 1'b1;
    for (int k = 0; k < 23; k++) begin
      pr = 3'($urandom_range(7, 1));
      delay <= 2'($urandom());
      wr(8'h40 + 8'(4 * k), {29'h0, pr});
      wr(8'h04, 32'h1);
      pulse(23'h1 << k, 1'b0, 6'h00);
      wait_ack(6'(nums[k]));
      chk({12'h0, taken.vector_addr},
        {12'h0, base + 20'(4 * nums[k])});
      chk({29'h0, taken.level}, {29'h0, pr});
      rd(8'h40 + 8'(4 * k), {29'h0, pr});
      rd(8'h04, {25'h0, pr, 4'h0});
    end
    $display("map test done");
    go <= 1'b0;
    wr(8'h7C, 32'h3);
    wr(8'h04, 32'h31);
    pulse(23'h1 << 15, 1'b0, 6'h00);
    see(1'b0, 6'h00);
    rd(8'h7C, 32'hB);
    wr(8'h04, 32'h21);
    see(1'b1, 6'h15);
    rd(8'h08, 32'h8315);
    wr(8'h04, 32'h20);
    see(1'b0, 6'h00);
    wr(8'h7C, 32'h7);
    pulse(23'h1 << 15, 1'b0, 6'h00);
    wr(8'h04, 32'h71);
    see(1'b0, 6'h00);
    wr(8'h04, 32'h61);
    see(1'b1, 6'h15);
    wr(8'h7C, 32'h7);
    see(1'b0, 6'h00);
    rd(8'h7C, 32'h7);
    wr(8'h40, 32'h0);
    wr(8'h04, 32'h01);
    pulse(23'h1, 1'b0, 6'h00);
    see(1'b0, 6'h00);
    rd(8'h40, 32'h8);
    wr(8'h40, 32'h0);
    $display("gating test done");
    wr(8'h4C, 32'h5);
    wr(8'h50, 32'h5);
    wr(8'h68, 32'h6);
    pulse(23'h418, 1'b0, 6'h00);
    see(1'b1, 6'h10);
    go <= 1'b1;
    wait_ack(6'h10);
    wr(8'h04, 32'h01);
    wait_ack(6'h07);
    wr(8'h04, 32'h01);
    wait_ack(6'h08);
    $display("arbitration test done");
    finish_test();
  end
endmodule // mivc_top_test

bind mivc_top mivc_chk #(.NSRC(NSRC)) chk_u (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req),
  .trap_req(trap_req), .trap_num(trap_num), .cpu_ack(cpu_ack),
  .irq_offer(irq_offer), .trap_offer(trap_offer));

// *** design/mivc_pkg.sv ***
/*
  constants and carrier types for the maskable interrupt vector control.
  assumes a single clock and a plain register port with one-cycle reads.
*/
package mivc_pkg;

  // ==========================================================
  // sizes
  localparam int NSRC = 23;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int RADDR_W = 8;
  localparam int NUM_W = 6;
  localparam int LVL_W = 3;
  localparam int IDX_W = 5;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_TABLE_BASE = 8'h00;
  localparam logic [7:0] OFF_FLAG_WORD = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CTRL_FIRST = 8'h40;
  localparam logic [7:0] OFF_CTRL_LAST = 8'h98;

  // ==========================================================
  // field positions
  localparam int FLAG_ENABLE_BIT = 0;
  localparam int FLAG_PPL_LSB = 4;
  localparam int CTRL_PRIO_LSB = 0;
  localparam int CTRL_REQ_BIT = 3;
  localparam int STAT_VALID_BIT = 15;
  localparam int STAT_LVL_LSB = 8;
  localparam int STAT_NUM_LSB = 0;

  // ==========================================================
  // reset values and fixed codes
  localparam logic [ADDR_W-1:0] TABLE_BASE_RST = 20'h00000;
  localparam logic [LVL_W-1:0] PPL_RST = 3'h0;
  localparam logic [LVL_W-1:0] PRIO_RST = 3'h0;
  localparam logic [LVL_W-1:0] PPL_ALL_BLOCKED = 3'h7;
  localparam logic [NUM_W-1:0] BREAKPOINT_NUM = 6'h00;
  localparam logic [NUM_W-1:0] SWONLY_FIRST = 6'h20;
  localparam int SLOT_SHIFT = 2;
  localparam int TABLE_BYTES = 256;

  // ==========================================================
  // what the core is offered
  typedef struct packed {
    logic valid;
    logic [NUM_W-1:0] number;
    logic [LVL_W-1:0] level;
    logic [ADDR_W-1:0] vector_addr;
  } mivc_offer_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [RADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mivc_reg_req_t;

endpackage

// *** design/mivc_top.sv ***
/*
  maskable interrupt vector control: per-source request and priority
  registers, global enable and processor priority level, arbitration and
  vector address generation for the core.
  assumes inputs synchronous to clk, source requests as one-cycle pulses,
  and a core that acknowledges the offered interrupt with a one-cycle pulse.
*/
// Overview of operation
// RULE1 - vector table starts at table base register
// RULE2 - vector area spans 256 bytes from base
// RULE3 - each slot four bytes, number n at 4n
// RULE4 - slot offsets relative to table base
// RULE5 - number 0 is breakpoint, never gated
// RULE6 - ext pins 3,4,5 map to 7,8,9
// RULE7 - dma 11,12; adc 14; serial 15; display 16
// RULE8 - uart0 tx/rx 17,18; uart1 19,20
// RULE9 - first timers 21-25, second timers 26-28
// RULE10 - ext pins 0,1,2 map to 29,30,31
// RULE11 - numbers 32-63 software only, never gated
// RULE12 - gating applies only to maskable sources
// RULE13 - each source has request and priority register
// RULE14 - enable and level live in flag word
// RULE15 - enable one admits, zero blocks maskables
// RULE16 - global enable cleared by reset
// RULE17 - hardware sets request bit on request
// RULE18 - request bit cleared on acceptance
// RULE19 - software may only clear request bits
// RULE20 - accept needs enable, request, level above
// RULE21 - three-bit priority, zero disables source
// RULE22 - level seven blocks all maskables
// RULE23 - acceptance loads level into processor level
// RULE24 - highest level wins, lowest source breaks ties
`timescale 1ns/10ps

module mivc_top #(
  parameter int NSRC = mivc_pkg::NSRC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [mivc_pkg::RADDR_W-1:0] reg_addr,
  input wire logic [mivc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mivc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [NSRC-1:0] src_req,
  input wire logic trap_req,
  input wire logic [mivc_pkg::NUM_W-1:0] trap_num,
  input wire logic cpu_ack,
  output mivc_pkg::mivc_offer_t irq_offer,
  output mivc_pkg::mivc_offer_t trap_offer
);

  // ==========================================================
  // source number to software interrupt number
  // index: 0-5 ext pins, 6-7 dma, 8 adc, 9 serial auto, 10 display,
  // 11-14 uart0 tx/rx uart1 tx/rx, 15-19 first timers, 20-22 second
  function automatic logic [mivc_pkg::NUM_W-1:0] src_number(
    input logic [mivc_pkg::IDX_W-1:0] idx
  );
    logic [mivc_pkg::NUM_W-1:0] n;
    n = 6'h00;
    case (idx)
      5'h00: n = 6'h1D; // [RULE10]
      5'h01: n = 6'h1E; // [RULE10]
      5'h02: n = 6'h1F; // [RULE10]
      5'h03: n = 6'h07; // [RULE6]
      5'h04: n = 6'h08; // [RULE6]
      5'h05: n = 6'h09; // [RULE6]
      5'h06: n = 6'h0B; // [RULE7]
      5'h07: n = 6'h0C; // [RULE7]
      5'h08: n = 6'h0E; // [RULE7]
      5'h09: n = 6'h0F; // [RULE7]
      5'h0A: n = 6'h10; // [RULE7]
      5'h0B: n = 6'h11; // [RULE8]
      5'h0C: n = 6'h12; // [RULE8]
      5'h0D: n = 6'h13; // [RULE8]
      5'h0E: n = 6'h14; // [RULE8]
      5'h0F: n = 6'h15; // [RULE9]
      5'h10: n = 6'h16; // [RULE9]
      5'h11: n = 6'h17; // [RULE9]
      5'h12: n = 6'h18; // [RULE9]
      5'h13: n = 6'h19; // [RULE9]
      5'h14: n = 6'h1A; // [RULE9]
      5'h15: n = 6'h1B; // [RULE9]
      5'h16: n = 6'h1C; // [RULE9]
      default: n = 6'h00;
    endcase
    return n;
  endfunction

  // slot address: base plus four times the number, always inside the
  // 256-byte window because the number is six bits wide
  function automatic logic [mivc_pkg::ADDR_W-1:0] slot_addr(
    input logic [mivc_pkg::ADDR_W-1:0] base,
    input logic [mivc_pkg::NUM_W-1:0] num
  );
    logic [mivc_pkg::ADDR_W-1:0] off;
    off = mivc_pkg::ADDR_W'({num, 2'b00}); // [RULE3] [RULE2]
    return base + off; // [RULE1] [RULE4]
  endfunction

  // ==========================================================
  // state
  logic [mivc_pkg::ADDR_W-1:0] table_base_q;
  logic [mivc_pkg::ADDR_W-1:0] table_base_d;
  logic enable_q;
  logic enable_d;
  logic [mivc_pkg::LVL_W-1:0] ppl_q;
  logic [mivc_pkg::LVL_W-1:0] ppl_d;
  logic [NSRC-1:0] req_q;
  logic [mivc_pkg::LVL_W-1:0] prio_q [NSRC];
  logic [mivc_pkg::IDX_W-1:0] offer_src_q;
  logic [mivc_pkg::IDX_W-1:0] offer_src_d;
  mivc_pkg::mivc_offer_t offer_q;
  mivc_pkg::mivc_offer_t offer_d;
  mivc_pkg::mivc_offer_t trap_q;
  mivc_pkg::mivc_offer_t trap_d;
  logic [mivc_pkg::DATA_W-1:0] rdata_q;
  logic [mivc_pkg::DATA_W-1:0] rdata_d;

  // ==========================================================
  // address decode
  wire logic hit_base = reg_addr == mivc_pkg::OFF_TABLE_BASE;
  wire logic hit_flag = reg_addr == mivc_pkg::OFF_FLAG_WORD;
  wire logic hit_stat = reg_addr == mivc_pkg::OFF_STATUS;
  wire logic hit_ctrl = reg_addr >= mivc_pkg::OFF_CTRL_FIRST &&
                        reg_addr <= mivc_pkg::OFF_CTRL_LAST &&
                        reg_addr[1:0] == 2'b00;
  wire logic [mivc_pkg::RADDR_W-1:0] ctrl_off =
    reg_addr - mivc_pkg::OFF_CTRL_FIRST;
  wire logic [mivc_pkg::IDX_W-1:0] ctrl_idx =
    ctrl_off[mivc_pkg::IDX_W+1:2];
  wire logic wr_flag = reg_wr && hit_flag;
  wire logic accept = cpu_ack && offer_q.valid;

  // ==========================================================
  // per-source control registers
  logic [NSRC-1:0] gated;
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      wire logic wr_this = reg_wr && hit_ctrl &&
                           ctrl_idx == mivc_pkg::IDX_W'(g);
      // software writes of 1 are ignored, only 0 clears
      wire logic sw_clr = wr_this &&
                          !reg_wdata[mivc_pkg::CTRL_REQ_BIT]; // [RULE19]
      wire logic hw_clr = accept &&
                          offer_src_q == mivc_pkg::IDX_W'(g); // [RULE18]
      always_ff @(posedge clk) begin
        if (reset) begin
          req_q[g] <= 1'b0;
          prio_q[g] <= mivc_pkg::PRIO_RST;
        end else begin
          // a new request beats either clear in the same cycle
          if (src_req[g]) begin
            req_q[g] <= 1'b1; // [RULE17]
          end else if (sw_clr || hw_clr) begin
            req_q[g] <= 1'b0; // [RULE18] [RULE19]
          end
          if (wr_this) begin
            prio_q[g] <= reg_wdata[mivc_pkg::CTRL_PRIO_LSB +: 3]; // [RULE13]
          end
        end
      end
      // level zero never exceeds the processor level, so it disables;
      // processor level seven leaves nothing above it
      assign gated[g] = enable_q && req_q[g] &&
                        prio_q[g] > ppl_q; // [RULE20] [RULE21] [RULE22]
    end
  endgenerate

  // ==========================================================
  // arbitration: highest level, lowest index on ties
  logic [mivc_pkg::LVL_W-1:0] best_lvl;
  logic [mivc_pkg::IDX_W-1:0] best_idx;
  logic best_hit;
  always_comb begin
    best_lvl = 3'h0;
    best_idx = 5'h00;
    best_hit = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      // strict compare keeps the earlier source on a tie
      if (gated[i] && (!best_hit || prio_q[i] > best_lvl)) begin // [RULE24]
        best_hit = 1'b1;
        best_lvl = prio_q[i];
        best_idx = mivc_pkg::IDX_W'(i);
      end
    end
  end

  // the offer is withdrawn after an accept until enable is written back to one, so the core
  // never sees the accepted source again before its bit is cleared
  always_comb begin
    offer_d.valid = best_hit && !accept && enable_d; // [RULE15]
    offer_d.number = src_number(best_idx);
    offer_d.level = best_lvl;
    offer_d.vector_addr = slot_addr(table_base_d, src_number(best_idx));
    offer_src_d = best_idx;
  end

  // ==========================================================
  // software traps: never gated by enable or level
  always_comb begin
    trap_d.valid = trap_req; // [RULE5] [RULE11] [RULE12]
    trap_d.number = trap_num;
    trap_d.level = 3'h0;
    trap_d.vector_addr = slot_addr(table_base_q, trap_num); // [RULE5] [RULE11]
  end

  // ==========================================================
  // flag word and table base
  always_comb begin
    table_base_d = table_base_q;
    if (reg_wr && hit_base) begin
      table_base_d = reg_wdata[mivc_pkg::ADDR_W-1:0]; // [RULE1]
    end
  end

  always_comb begin
    enable_d = enable_q;
    ppl_d = ppl_q;
    if (accept) begin
      // acceptance wins over a write in the same cycle
      enable_d = 1'b0;
      ppl_d = offer_q.level; // [RULE23]
    end else if (wr_flag) begin
      enable_d = reg_wdata[mivc_pkg::FLAG_ENABLE_BIT]; // [RULE14] [RULE15]
      ppl_d = reg_wdata[mivc_pkg::FLAG_PPL_LSB +: 3]; // [RULE14]
    end
  end

  // ==========================================================
  // register read
  logic [mivc_pkg::DATA_W-1:0] ctrl_word;
  always_comb begin
    ctrl_word = '0;
    if (ctrl_idx < mivc_pkg::IDX_W'(NSRC)) begin
      ctrl_word[mivc_pkg::CTRL_PRIO_LSB +: 3] = prio_q[ctrl_idx];
      ctrl_word[mivc_pkg::CTRL_REQ_BIT] = req_q[ctrl_idx];
    end
  end

  always_comb begin
    rdata_d = '0;
    if (!reg_rd) begin
      rdata_d = '0;
    end else if (hit_base) begin
      rdata_d[mivc_pkg::ADDR_W-1:0] = table_base_q;
    end else if (hit_flag) begin
      rdata_d[mivc_pkg::FLAG_ENABLE_BIT] = enable_q;
      rdata_d[mivc_pkg::FLAG_PPL_LSB +: 3] = ppl_q;
    end else if (hit_stat) begin
      rdata_d[mivc_pkg::STAT_VALID_BIT] = offer_q.valid;
      rdata_d[mivc_pkg::STAT_LVL_LSB +: 3] = offer_q.level;
      rdata_d[mivc_pkg::STAT_NUM_LSB +: 6] = offer_q.number;
    end else if (hit_ctrl) begin
      rdata_d = ctrl_word;
    end
  end

  // ==========================================================
  // flip-flops
  always_ff @(posedge clk) begin
    if (reset) begin
      table_base_q <= mivc_pkg::TABLE_BASE_RST;
      enable_q <= 1'b0; // [RULE16]
      ppl_q <= mivc_pkg::PPL_RST;
      offer_q <= '0;
      offer_src_q <= '0;
      trap_q <= '0;
      rdata_q <= '0;
    end else begin
      table_base_q <= table_base_d;
      enable_q <= enable_d;
      ppl_q <= ppl_d;
      offer_q <= offer_d;
      offer_src_q <= offer_src_d;
      trap_q <= trap_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq_offer = offer_q;
  assign trap_offer = trap_q;

endmodule // mivc_top
